// file: hdl/ssf_status.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - status resets or standby to 84 hex
// R2 - flag writes of one ignored; read-then-zero clears
// R3 - transmit end and multiproc bit read-only
// R4 - tx empty set: reset, tx disable, shifter load
// R5 - tx empty cleared by dma write or software
// R6 - rx full set on clean received character
// R7 - rx full cleared: reset, software, dma read
// R8 - rx errors leave full; disable leaves buffer, full
// R9 - overrun set when char ends with full
// R10 - overrun keeps old char, drops new
// R11 - overrun/framing stop rx; sync stops tx
// R12 - rx disable leaves overrun, framing unchanged
// R13 - framing set when async stop bit zero
// R14 - two stop bits: only first checked
// R15 - framing error loads buffer, not full
// R16 - overrun, framing cleared by reset, software
// R17 - parity flag on count mismatch
// R18 - tx end on last bit with empty
// R19 - multiproc filter blocks until mpb one
// R20 - hardware set beats software clear
module ssf_status
   import ssf_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic standby_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // dma side strobes
   input wire logic dma_tx_wr_i,
   input wire logic [7:0] dma_tx_data_i,
   input wire logic dma_rx_rd_i,
   // transmit datapath
   input wire logic tx_load_i,
   input wire logic tx_last_bit_i,
   output logic [7:0] tx_data_o,
   output logic tx_hold_o,
   // receive datapath
   input wire logic rx_done_i,
   input wire ssf_rx_char_t rx_char_i,
   output logic rx_hold_o,
   // state shown to the datapaths
   output logic [7:0] status_o,
   output logic [7:0] ctrl_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic txe_q, rxf_q, ovr_q, frm_q, par_q, transmit_end_flag_q, mpb_q;
   logic [7:0] ctrl_q;
   logic [7:0] rxbuf_q;
   logic [7:0] txbuf_q;
   logic [7:0] seen_q;
   logic [7:0] rdata_q;
   logic init;
   logic txen, rxen, sync_m, mpf;
   logic sw_st_wr, sw_ctl_wr, sw_tx_wr;
   logic [7:0] sw_clr;
   logic par_err, frm_err;
   logic rx_ok_done, rx_take, set_rxf, set_ovr, set_frm, set_par;
   logic load_buf, txen_fall, set_txe, mpf_release;
   logic [7:0] status_now;

   assign init = standby_i; // standby acts as a synchronous reset
   assign txen = ctrl_q[SSF_CTL_TXEN];
   assign rxen = ctrl_q[SSF_CTL_RXEN];
   assign sync_m = ctrl_q[SSF_CTL_SYNC];
   assign mpf = ctrl_q[SSF_CTL_MPF];

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // a flag clears on a zero write only if it was read as one before
   function automatic logic [7:0] clr_ok(input logic [7:0] seen,
      input logic [7:0] wbits);
      clr_ok = seen & ~wbits;
   endfunction

   ssf_rx_check u_chk (
      .chr_i(rx_char_i),
      .par_en_i(ctrl_q[SSF_CTL_PAREN]),
      .par_odd_i(ctrl_q[SSF_CTL_ODD]),
      .async_i(~sync_m),
      .par_err_o(par_err),
      .frm_err_o(frm_err)
   );

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign sw_st_wr = wr_i & (addr_i == SSF_ADDR_STATUS);
   assign sw_ctl_wr = wr_i & (addr_i == SSF_ADDR_CTRL);
   assign sw_tx_wr = wr_i & (addr_i == SSF_ADDR_TXBUF);
   assign sw_clr = sw_st_wr ? clr_ok(seen_q, wdata_i) : 8'h00; // R2

   // receive event qualification
   assign rx_hold_o = ovr_q | frm_q | par_q; // R11
   // filter: characters with mpb zero are dropped silently
   assign rx_take = rx_done_i & rxen & ~rx_hold_o &
                    (~mpf | rx_char_i.received_multiproc_bit); // R19
   assign mpf_release = rx_take & mpf;
   assign set_ovr = rx_take & rxf_q; // R9
   assign set_frm = rx_take & ~rxf_q & frm_err; // R13
   assign set_par = rx_take & ~rxf_q & ~frm_err & par_err; // R17
   assign rx_ok_done = rx_take & ~rxf_q & ~frm_err & ~par_err;
   assign set_rxf = rx_ok_done; // R6
   // framing/parity errors still load; overrun does not
   assign load_buf = rx_take & ~rxf_q; // R10 R15
   assign tx_hold_o = sync_m & rx_hold_o; // R11
   assign txen_fall = sw_ctl_wr & txen & ~wdata_i[SSF_CTL_TXEN];
   assign set_txe = tx_load_i | txen_fall; // R4

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   // mpb one seen under filtering turns the filter off
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_q <= SSF_CTRL_RST;
      else if (init)
         ctrl_q <= SSF_CTRL_RST;
      else if (sw_ctl_wr)
         ctrl_q <= wdata_i & SSF_CTRL_WMASK;
      else if (mpf_release)
         ctrl_q[SSF_CTL_MPF] <= 1'b0; // R19
   end

   // ---------------------------------------------------------------
   // transmit flags
   // ---------------------------------------------------------------
   // set first in each branch so a coincident clear loses
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         txe_q <= SSF_STATUS_RST[SSF_BIT_TXE]; // R1
      else if (init)
         txe_q <= 1'b1; // R4
      else if (set_txe)
         txe_q <= 1'b1; // R4 R20
      else if (dma_tx_wr_i | sw_clr[SSF_BIT_TXE])
         txe_q <= 1'b0; // R5
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         transmit_end_flag_q <= SSF_STATUS_RST[SSF_BIT_TRANSMIT_END_FLAG]; // R1
      else if (init)
         transmit_end_flag_q <= 1'b1;
      else if (txen_fall | (tx_last_bit_i & txe_q))
         transmit_end_flag_q <= 1'b1; // R18 R20
      else if (dma_tx_wr_i | sw_clr[SSF_BIT_TXE])
         transmit_end_flag_q <= 1'b0; // R3
   end

   // holding buffer, written by software or dma
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         txbuf_q <= 8'h00;
      else if (dma_tx_wr_i)
         txbuf_q <= dma_tx_data_i;
      else if (sw_tx_wr)
         txbuf_q <= wdata_i;
   end

   // ---------------------------------------------------------------
   // receive flags
   // ---------------------------------------------------------------
   // rx disable does not touch these: only reset, clears and sets
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rxf_q <= SSF_STATUS_RST[SSF_BIT_RXF]; // R1
      else if (init)
         rxf_q <= 1'b0; // R7
      else if (set_rxf)
         rxf_q <= 1'b1; // R6 R20
      else if (dma_rx_rd_i | sw_clr[SSF_BIT_RXF])
         rxf_q <= 1'b0; // R7 R8
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ovr_q <= SSF_STATUS_RST[SSF_BIT_OVR];
      else if (init)
         ovr_q <= 1'b0; // R16
      else if (set_ovr)
         ovr_q <= 1'b1; // R9 R20
      else if (sw_clr[SSF_BIT_OVR])
         ovr_q <= 1'b0; // R12 R16
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         frm_q <= SSF_STATUS_RST[SSF_BIT_FRM];
      else if (init)
         frm_q <= 1'b0; // R16
      else if (set_frm)
         frm_q <= 1'b1; // R13 R20
      else if (sw_clr[SSF_BIT_FRM])
         frm_q <= 1'b0; // R12 R16
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         par_q <= SSF_STATUS_RST[SSF_BIT_PAR];
      else if (init)
         par_q <= 1'b0;
      else if (set_par)
         par_q <= 1'b1; // R17 R20
      else if (sw_clr[SSF_BIT_PAR])
         par_q <= 1'b0; // R2
   end

   // multiproc bit follows each accepted character, read-only
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         mpb_q <= SSF_STATUS_RST[SSF_BIT_MPB];
      else if (init)
         mpb_q <= 1'b0;
      else if (rx_take)
         mpb_q <= rx_char_i.received_multiproc_bit; // R3
   end

   // receive holding buffer: an overrun keeps the older character
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rxbuf_q <= 8'h00;
      else if (load_buf)
         rxbuf_q <= rx_char_i.data; // R8 R10 R15
   end

   // ---------------------------------------------------------------
   // read-as-one tracking
   // ---------------------------------------------------------------
   assign status_now = {txe_q, rxf_q, ovr_q, frm_q, par_q, transmit_end_flag_q,
                        mpb_q, 1'b0};

   // remembers which flags software saw set; a later write consumes it
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         seen_q <= 8'h00;
      else if (init)
         seen_q <= 8'h00;
      else if (rd_i & (addr_i == SSF_ADDR_STATUS))
         seen_q <= status_now & 8'hF8; // R2
      else if (sw_st_wr)
         seen_q <= 8'h00;
      else
         seen_q <= seen_q & status_now;
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   // unmapped addresses read zero
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_q <= 8'h00;
      else if (rd_i)
      begin
         case (addr_i)
            SSF_ADDR_STATUS: rdata_q <= status_now;
            SSF_ADDR_CTRL: rdata_q <= ctrl_q;
            SSF_ADDR_RXBUF: rdata_q <= rxbuf_q;
            SSF_ADDR_TXBUF: rdata_q <= txbuf_q;
            default: rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   assign rdata_o = rdata_q;
   assign tx_data_o = txbuf_q;
   assign status_o = status_now;
   assign ctrl_o = ctrl_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb_chk @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_full_then_char;
      rxf_q ##0 (rx_take & ~init);
   endsequence

   a_reset_value: assert property ( // R1
      init |=> status_now == SSF_STATUS_RST)
      else $error("status not at reset value after standby");
   a_one_write_inert: assert property ( // R2
      (sw_st_wr & wdata_i[SSF_BIT_RXF] & rxf_q & ~init & ~dma_rx_rd_i)
      |=> rxf_q)
      else $error("writing one cleared receive full");
   a_txe_set_load: assert property ( // R4
      tx_load_i |=> txe_q)
      else $error("tx empty not set after shifter load");
   a_txe_dma_clear: assert property ( // R5
      (dma_tx_wr_i & ~set_txe & ~init) |=> ~txe_q)
      else $error("tx empty not cleared by dma write");
   a_overrun_keeps: assert property ( // R9 R10
      s_full_then_char |=> ovr_q && rxbuf_q == $past(rxbuf_q))
      else $error("overrun mishandled");
   a_hold_blocks_rx: assert property ( // R11
      (ovr_q | frm_q) & rx_done_i & ~init |=> $stable(rxbuf_q))
      else $error("reception continued with error flag set");
   a_frame_no_full: assert property ( // R13 R15
      (rx_take & ~rxf_q & frm_err & ~init) |=> frm_q && ~rxf_q
      && rxbuf_q == $past(rx_char_i.data))
      else $error("framing error handling wrong");
   a_filter_blocks: assert property ( // R19
      (mpf & rx_done_i & ~rx_char_i.received_multiproc_bit & ~init) |=>
      $stable(rxbuf_q) && !$rose(rxf_q))
      else $error("filtered character changed receive state");
   a_set_wins: assert property ( // R20
      (set_rxf & sw_clr[SSF_BIT_RXF] & ~init) |=> rxf_q)
      else $error("clear beat hardware set");

endmodule

// file: hdl/ssf_pkg.sv
package ssf_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0] SSF_ADDR_STATUS = 4'h0;
   localparam logic [3:0] SSF_ADDR_CTRL = 4'h1;
   localparam logic [3:0] SSF_ADDR_RXBUF = 4'h2;
   localparam logic [3:0] SSF_ADDR_TXBUF = 4'h3;

   // ---------------------------------------------------------------
   // status field positions and reset value
   // ---------------------------------------------------------------
   localparam int SSF_BIT_TXE = 7;
   localparam int SSF_BIT_RXF = 6;
   localparam int SSF_BIT_OVR = 5;
   localparam int SSF_BIT_FRM = 4;
   localparam int SSF_BIT_PAR = 3;
   localparam int SSF_BIT_TRANSMIT_END_FLAG = 2;
   localparam int SSF_BIT_MPB = 1;
   localparam logic [7:0] SSF_STATUS_RST = 8'h84;

   // ---------------------------------------------------------------
   // control field positions and reset value
   // ---------------------------------------------------------------
   localparam int SSF_CTL_TXEN = 0;
   localparam int SSF_CTL_RXEN = 1;
   localparam int SSF_CTL_SYNC = 2;
   localparam int SSF_CTL_MPF = 3;
   localparam int SSF_CTL_ODD = 4;
   localparam int SSF_CTL_PAREN = 5;
   localparam logic [7:0] SSF_CTRL_RST = 8'h00;
   localparam logic [7:0] SSF_CTRL_WMASK = 8'h3F;

   // received character with its frame bits
   typedef struct packed {
      logic [7:0] data;
      logic       parity;
      logic       received_multiproc_bit;
      logic       stop1;
   } ssf_rx_char_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ssf_req_t;

endpackage

// file: hdl/ssf_rx_check.sv
`timescale 1ns/1ps
module ssf_rx_check
   import ssf_pkg::*;
(
   // character and frame setup
   input wire ssf_rx_char_t chr_i,
   input wire logic par_en_i,
   input wire logic par_odd_i,
   input wire logic async_i,
   // verdicts
   output logic par_err_o,
   output logic frm_err_o
);

   // ---------------------------------------------------------------
   // error checks
   // ---------------------------------------------------------------
   // only the first stop bit is looked at; a second one never reaches here
   always_comb
   begin
      par_err_o = par_en_i & async_i &
                  ((^{chr_i.data, chr_i.parity}) != par_odd_i); // R17
      frm_err_o = async_i & ~chr_i.stop1; // R13 R14
   end

endmodule

// file: sim/ssf_far_end.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// remote station: frames characters and shifter events
// ---------------------------------------------------------------
module ssf_far_end
   import ssf_pkg::*;
(
   // clock
   input wire logic clk_i,
   // datapath events
   output logic rx_done_o,
   output ssf_rx_char_t rx_char_o,
   output logic tx_load_o,
   output logic tx_last_bit_o
);
   // idle at time zero, no character pending
   initial
   begin
      rx_done_o = 1'b0;
      rx_char_o = ssf_rx_char_t'(11'h000);
      tx_load_o = 1'b0;
      tx_last_bit_o = 1'b0;
   end

   // one character, valid only beside its done pulse; afterwards the
   // lines show the inverse so a late sample cannot look right
   task automatic send(input logic [7:0] d, input logic p,
      input logic m, input logic s);
      @(posedge clk_i);
      rx_done_o <= 1'b1;
      rx_char_o <= ssf_rx_char_t'({d, p, m, s});
      @(posedge clk_i);
      rx_done_o <= 1'b0;
      rx_char_o <= ssf_rx_char_t'(~{d, p, m, s});
   endtask

   // shifter event: load from holding buffer, or last bit shifted out
   task automatic shift(input logic last);
      @(posedge clk_i);
      tx_load_o <= ~last;
      tx_last_bit_o <= last;
      @(posedge clk_i);
      tx_load_o <= 1'b0;
      tx_last_bit_o <= 1'b0;
   endtask
endmodule

// file: sim/ssf_status_tb.sv
`timescale 1ns/1ps
module ssf_status_tb;
   import ssf_pkg::*;
   // ---------------------------------------------------------------
   // clock, reset and design inputs
   // ---------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic standby_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic dma_tx_wr_i = 1'b0;
   logic [7:0] dma_tx_data_i = 8'h00;
   logic dma_rx_rd_i = 1'b0;
   logic [7:0] rdata_o, tx_data_o, status_o, ctrl_o, s, b;
   logic tx_hold_o, rx_hold_o, rx_done, tx_load, tx_last;
   ssf_rx_char_t rx_char;
   int errors = 0;
   int checks_done = 0;

   always #50 clk_i = ~clk_i;

   ssf_status u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .standby_i(standby_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .dma_tx_wr_i(dma_tx_wr_i), .dma_tx_data_i(dma_tx_data_i),
      .dma_rx_rd_i(dma_rx_rd_i), .tx_load_i(tx_load),
      .tx_last_bit_i(tx_last), .tx_data_o(tx_data_o),
      .tx_hold_o(tx_hold_o), .rx_done_i(rx_done),
      .rx_char_i(rx_char), .rx_hold_o(rx_hold_o),
      .status_o(status_o), .ctrl_o(ctrl_o));

   ssf_far_end u_far (.clk_i(clk_i), .rx_done_o(rx_done),
      .rx_char_o(rx_char), .tx_load_o(tx_load),
      .tx_last_bit_o(tx_last));

   // ---------------------------------------------------------------
   // access tasks and comparisons
   // ---------------------------------------------------------------
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stands one cycle only, so status is kept in s
   task automatic rs;
      rd(SSF_ADDR_STATUS, s);
   endtask

   // one-cycle strobe: standby, dma tx write, dma rx read
   task automatic pulse(input logic [2:0] which);
      @(posedge clk_i);
      {standby_i, dma_tx_wr_i, dma_rx_rd_i} <= which;
      @(posedge clk_i);
      {standby_i, dma_tx_wr_i, dma_rx_rd_i} <= 3'h0;
   endtask

   task automatic chk8(input string n, input logic [7:0] e,
      input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input int p);
      checks_done++;
      if (s[p] !== e)
      begin
         errors++;
         $display("ERROR %s expected %b seen %b", n, e, s[p]);
      end
   endtask

   task automatic test_done;
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // hang guard: a stuck run ends in the same report
   initial
   begin
      repeat (5000) @(posedge clk_i);
      errors++;
      test_done();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rs();
      chk8("status reset", SSF_STATUS_RST, s);
      wr(SSF_ADDR_STATUS, 8'hFF);
      rs();
      chk8("status after ones", SSF_STATUS_RST, s);
      // any status write uses up the read record, so the zero is inert
      wr(SSF_ADDR_STATUS, 8'h80);
      wr(SSF_ADDR_STATUS, 8'h00);
      rs();
      chk_bit("tx empty unread", 1'b1, SSF_BIT_TXE);
      // transmit side: dma fill, shifter load, last bit
      wr(SSF_ADDR_CTRL, 8'h03);
      dma_tx_data_i <= 8'h5A;
      pulse(3'h2);
      rs();
      chk_bit("tx empty dma", 1'b0, SSF_BIT_TXE);
      chk_bit("tx end dma", 1'b0, SSF_BIT_TRANSMIT_END_FLAG);
      chk8("tx data", 8'h5A, tx_data_o);
      u_far.shift(1'b1);
      rs();
      chk_bit("tx end busy", 1'b0, SSF_BIT_TRANSMIT_END_FLAG);
      u_far.shift(1'b0);
      u_far.shift(1'b1);
      rs();
      chk_bit("tx empty load", 1'b1, SSF_BIT_TXE);
      chk_bit("tx end done", 1'b1, SSF_BIT_TRANSMIT_END_FLAG);
      wr(SSF_ADDR_STATUS, 8'h00);
      rs();
      chk_bit("tx empty sw", 1'b0, SSF_BIT_TXE);
      wr(SSF_ADDR_CTRL, 8'h02);
      rs();
      chk_bit("tx empty disable", 1'b1, SSF_BIT_TXE);
      // receive side: clean char, overrun, held reception
      u_far.send(8'h3C, 1'b0, 1'b0, 1'b1);
      rs();
      chk_bit("rx full", 1'b1, SSF_BIT_RXF);
      wr(SSF_ADDR_STATUS, 8'hFF);
      u_far.send(8'hA5, 1'b0, 1'b0, 1'b1);
      rs();
      chk_bit("rx full ones", 1'b1, SSF_BIT_RXF);
      chk_bit("overrun", 1'b1, SSF_BIT_OVR);
      chk8("rx hold", 8'h01, {7'h00, rx_hold_o});
      chk8("tx hold async", 8'h00, {7'h00, tx_hold_o});
      wr(SSF_ADDR_CTRL, 8'h06);
      #1 chk8("tx hold sync", 8'h01, {7'h00, tx_hold_o});
      wr(SSF_ADDR_CTRL, 8'h02);
      u_far.send(8'h77, 1'b0, 1'b0, 1'b1);
      rd(SSF_ADDR_RXBUF, b);
      chk8("rx buf kept", 8'h3C, b);
      pulse(3'h1);
      rs();
      chk_bit("rx full dma", 1'b0, SSF_BIT_RXF);
      wr(SSF_ADDR_STATUS, 8'h00);
      rs();
      chk_bit("overrun clear", 1'b0, SSF_BIT_OVR);
      // framing error loads buffer without full flag
      u_far.send(8'h99, 1'b0, 1'b0, 1'b0);
      rs();
      chk_bit("framing", 1'b1, SSF_BIT_FRM);
      chk_bit("rx full frm", 1'b0, SSF_BIT_RXF);
      rd(SSF_ADDR_RXBUF, b);
      chk8("rx buf frm", 8'h99, b);
      wr(SSF_ADDR_CTRL, 8'h00);
      rs();
      chk_bit("framing rx off", 1'b1, SSF_BIT_FRM);
      pulse(3'h4);
      rs();
      chk8("status standby", SSF_STATUS_RST, s);
      chk8("status port", SSF_STATUS_RST, status_o);
      chk8("ctrl standby", SSF_CTRL_RST, ctrl_o);
      // even parity: one data one plus parity zero is odd
      wr(SSF_ADDR_CTRL, 8'h22);
      u_far.send(8'h01, 1'b0, 1'b0, 1'b1);
      rs();
      chk_bit("parity", ^{8'h01, 1'b0}, SSF_BIT_PAR);
      // multiprocessor filter drops chars until mpb is one
      pulse(3'h4);
      wr(SSF_ADDR_CTRL, 8'h0A);
      u_far.send(8'h11, 1'b0, 1'b0, 1'b1);
      rs();
      chk_bit("rx full filter", 1'b0, SSF_BIT_RXF);
      u_far.send(8'h22, 1'b0, 1'b1, 1'b1);
      rs();
      chk_bit("rx full mpb", 1'b1, SSF_BIT_RXF);
      chk8("filter off", 8'h02, ctrl_o);
      wr(SSF_ADDR_STATUS, 8'h00);
      rs();
      chk_bit("mpb read only", 1'b1, SSF_BIT_MPB);
      chk_bit("rx full sw", 1'b0, SSF_BIT_RXF);
      // a character lands in the cycle of a clearing zero write; the dma
      // read one cycle before leaves the read record still live
      u_far.send(8'h44, 1'b0, 1'b1, 1'b1);
      rs();
      fork
         pulse(3'h1);
         begin
            @(posedge clk_i);
            wr(SSF_ADDR_STATUS, 8'h00);
         end
         begin
            @(posedge clk_i);
            u_far.send(8'h55, 1'b0, 1'b1, 1'b1);
         end
      join
      rs();
      chk_bit("set wins", 1'b1, SSF_BIT_RXF);
      test_done();
   end
endmodule
